// >>> hw/dfr_pkg.sv
package dfr_pkg;
  // timing
  localparam int CLK_MHZ       = 40;
  localparam int GATE_US       = 10_000;
  localparam int GATE_CYC      = GATE_US * CLK_MHZ;
  localparam int PULSE_MAX_KHZ = 100;
  // scaling and terminals
  localparam int FULL_SHIFT    = 14;
  localparam int HS_DI         = 4;
  localparam int NUM_CURVES    = 5;
  localparam int PULSE_CURVE   = 5;
  localparam int CURVE_WORDS   = 24;
  localparam int NUM_SRC       = 10;
  // terminal function codes
  localparam logic [7:0] FN_MS0     = 8'h0c;
  localparam logic [7:0] FN_CH_SW   = 8'h12;
  localparam logic [7:0] FN_LEN_CNT = 8'h1b;
  localparam logic [7:0] FN_LEN_CLR = 8'h1c;
  localparam logic [7:0] FN_PID_SW  = 8'h2b;
  // source codes
  localparam logic [3:0] SRC_DIG_V  = 4'h0;
  localparam logic [3:0] SRC_DIG_R  = 4'h1;
  localparam logic [3:0] SRC_AI1    = 4'h2;
  localparam logic [3:0] SRC_PULSE  = 4'h5;
  localparam logic [3:0] SRC_PRESET = 4'h6;
  localparam logic [3:0] SRC_SEQ    = 4'h7;
  localparam logic [3:0] SRC_PID    = 4'h8;
  localparam logic [3:0] SRC_HOST   = 4'h9;
  typedef enum logic [1:0] {
    CMB_MAIN = 2'b00, CMB_AUX = 2'b01, CMB_OP = 2'b10, CMB_SW = 2'b11
  } dfr_cmb_t;
  typedef enum logic [1:0] {
    OP_SUM = 2'b00, OP_DIFF = 2'b01, OP_MAX = 2'b10, OP_MIN = 2'b11
  } dfr_op_t;
  typedef enum logic [1:0] {
    SW_MA = 2'b00, SW_MC = 2'b01, SW_AC = 2'b10
  } dfr_sw_t;
  typedef enum logic {BUS_IDLE = 1'b0, BUS_DATA = 1'b1} dfr_bus_t;
  // control word fields
  localparam int CF_MAIN = 0;
  localparam int CF_AUX  = 4;
  localparam int CF_CMB  = 8;
  localparam int CF_OP   = 10;
  localparam int CF_SW   = 12;
  localparam int CF_DINV = 14;
  localparam int CF_RINH = 15;
  localparam int CF_CSRC = 16;
  localparam int CF_PAUT = 18;
  // register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_BIND   = 8'h04;
  localparam logic [7:0] REG_MAXF   = 8'h08;
  localparam logic [7:0] REG_CSEL   = 8'h0c;
  localparam logic [7:0] REG_DIG    = 8'h10;
  localparam logic [7:0] REG_HOST   = 8'h14;
  localparam logic [7:0] REG_FMAPL  = 8'h18;
  localparam logic [7:0] REG_FMAPH  = 8'h1c;
  localparam logic [7:0] REG_SETLEN = 8'h20;
  localparam logic [7:0] REG_PPM    = 8'h24;
  localparam logic [7:0] REG_PTHR   = 8'h28;
  localparam logic [7:0] REG_STAT   = 8'h2c;
  localparam logic [7:0] REG_ACTLEN = 8'h30;
  localparam logic [7:0] REG_TGT    = 8'h34;
  localparam logic [7:0] REG_LCNT   = 8'h38;
  localparam logic [7:0] REG_PRATE  = 8'h3c;
  localparam logic [7:0] CURVE_BASE = 8'h40;
  localparam logic [1:0] PRESET_TOP = 2'b11;
  // reset values
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [15:0] MAXF_RST   = 16'h1388;
  localparam logic [15:0] PPM_RST    = 16'h0001;
  localparam logic [31:0] SETLEN_RST = 32'h0000_03e8;
endpackage : dfr_pkg

// >>> hw/dfr_ram.sv
module dfr_ram #(
  parameter int W = 16,
  parameter int D = 16
) (
  // clock
  input  logic                 clock_in,
  // write port
  input  logic                 we_in,
  input  logic [$clog2(D)-1:0] waddr_in,
  input  logic [W-1:0]         wdata_in,
  // read ports, data registered
  input  logic [$clog2(D)-1:0] raddr_a_in,
  output logic [W-1:0]         rdata_a_out,
  input  logic [$clog2(D)-1:0] raddr_b_in,
  output logic [W-1:0]         rdata_b_out
);
  logic [W-1:0] mem_reg [D];

  if (D < 2 || W < 1) begin : g_chk
    $error("dfr_ram: depth or width unusable");
  end

  always_ff @(posedge clock_in) begin
    if (we_in) begin
      mem_reg[waddr_in] <= wdata_in;
    end
    rdata_a_out <= mem_reg[raddr_a_in];
    rdata_b_out <= mem_reg[raddr_b_in];
  end
endmodule : dfr_ram

// >>> hw/dfr_top.sv
// How it works
// R1: aux source has same modes, own select
// R2: single-source relation passes value unchanged
// R3: combine by sum, difference, max, min
// R4: terminal switches between channel pairs
// R5: bound command source overrides main and aux
// R6: analog full scale equals maximum frequency
// R7: five programmable curves for analog inputs
// R8: pulse input on high-speed terminal, 100 kHz
// R9: pulse rate mapped by two-point line
// R10: PID active only with main code 8
// R11: two PID units, auto or terminal switch
// R12: sixteen presets from functions 12 to 15
// R13: preset table used with main code 6
// R14: terminal bits index table, scaled by max
// R15: unassigned index bits read as zero
// R16: direction invert flips running direction
// R17: host negative setpoint commands reverse
// R18: reverse inhibit gives zero, no output
// R19: count function 27, divide by pulses/meter
// R20: length reached when actual exceeds set
// R21: function 28 clears accumulated length
// R22: count up only, high-speed terminal only
// R23: main select offers the ten modes
// R24: integer division, saturating pulse count
// R25: clamp combined result to max frequency
//
// The AHB-Lite interface to the registers and the address map were left to the implementer.
module dfr_top #(
  parameter int NUM_DI   = 8,
  parameter int GATE_CYC = dfr_pkg::GATE_CYC
) (
  // system
  input  logic               clock_in,
  input  logic               rstn_in,
  // ahb-lite slave
  input  logic               hsel_in,
  input  logic [31:0]        haddr_in,
  input  logic [1:0]         htrans_in,
  input  logic               hwrite_in,
  input  logic [2:0]         hsize_in,
  input  logic [31:0]        hwdata_in,
  input  logic               hready_in,
  output logic               hreadyout_out,
  output logic [31:0]        hrdata_out,
  output logic               hresp_out,
  // terminals and sources
  input  logic [NUM_DI-1:0]  di_in,
  input  logic signed [15:0] ai1_in,
  input  logic signed [15:0] ai2_in,
  input  logic signed [15:0] ai3_in,
  input  logic signed [15:0] seq_set_in,
  input  logic signed [15:0] pid0_in,
  input  logic signed [15:0] pid1_in,
  input  logic signed [15:0] pid_err_in,
  input  logic               run_cmd_in,
  input  logic               rev_cmd_in,
  // drive outputs
  output logic [15:0]        freq_out,
  output logic               reverse_out,
  output logic               drive_en_out,
  output logic               len_reached_out,
  output logic               pid_active_out,
  output logic               pid_unit_out
);
  // multiply first so a short gate window does not truncate the clamp to nothing
  localparam int PMAX_RAW = GATE_CYC * dfr_pkg::PULSE_MAX_KHZ / (dfr_pkg::CLK_MHZ * 1000);
  localparam logic [15:0] PMAX = 16'((PMAX_RAW < 1) ? 1 : PMAX_RAW);
  localparam logic [23:0] GC_LAST = 24'(GATE_CYC - 1);

  if (NUM_DI <= dfr_pkg::HS_DI || NUM_DI > 8 || GATE_CYC < 1 || GATE_CYC > 16777215)
  begin : g_chk
    $error("dfr_top: terminal count or gate length unusable");
  end

  function automatic logic dfr_has(input logic [7:0] lvl, input logic [63:0] fm,
                                   input logic [7:0] code);
    logic r;
    r = 1'b0;
    for (int i = 0; i < 8; i++) begin
      r = r | (lvl[i] & (fm[i*8 +: 8] == code));
    end
    return r;
  endfunction : dfr_has

  function automatic logic signed [15:0] dfr_curve(input logic signed [15:0] x,
    input logic signed [15:0] x0, input logic signed [15:0] y0,
    input logic signed [15:0] x1, input logic signed [15:0] y1);
    logic signed [15:0] xc;
    logic signed [16:0] dx;
    logic signed [33:0] num;
    xc  = (x < x0) ? x0 : ((x > x1) ? x1 : x);
    dx  = 17'(x1) - 17'(x0);
    num = 34'(17'(xc) - 17'(x0)) * 34'(17'(y1) - 17'(y0));
    if (dx <= 17'sd0) begin
      return y0;
    end
    return 16'(34'(y0) + num / 34'(dx));
  endfunction : dfr_curve

  function automatic logic signed [16:0] dfr_pick(input logic [9:0][15:0] s,
                                                  input logic [3:0] code);
    if (code >= 4'(dfr_pkg::NUM_SRC)) begin
      return 17'sd0;
    end
    return 17'($signed(s[code]));
  endfunction : dfr_pick

  // input synchronisers
  logic [NUM_DI-1:0] di_m_reg;
  logic [NUM_DI-1:0] di_s_reg;
  logic              hs_d_reg;
  logic [7:0]        lvl;
  logic              hs_edge;

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      di_m_reg <= '0;
      di_s_reg <= '0;
      hs_d_reg <= 1'b0;
    end else begin
      di_m_reg <= di_in;
      di_s_reg <= di_m_reg;
      hs_d_reg <= di_s_reg[dfr_pkg::HS_DI];
    end
  end
  assign lvl     = 8'(di_s_reg);
  assign hs_edge = di_s_reg[dfr_pkg::HS_DI] & ~hs_d_reg; // R8

  // bus and configuration state
  dfr_pkg::dfr_bus_t st_reg, st_next;
  logic [7:0]  a_reg, a_next;
  logic        w_reg, w_next;
  logic        rdy_reg, rdy_next;
  logic [31:0] rd_reg, rd_next, rd_mux;
  logic [31:0] ctrl_reg, ctrl_next;
  logic [11:0] bind_reg, bind_next;
  logic [15:0] maxf_reg, maxf_next;
  logic [8:0]  csel_reg, csel_next;
  logic [15:0] dig_reg, dig_next;
  logic [15:0] host_reg, host_next;
  logic [63:0] fmap_reg, fmap_next;
  logic [31:0] slen_reg, slen_next;
  logic [15:0] ppm_reg, ppm_next;
  logic [15:0] pthr_reg, pthr_next;
  logic [15:0] crv_reg [dfr_pkg::CURVE_WORDS];
  logic [15:0] crv_next [dfr_pkg::CURVE_WORDS];
  logic        wr_go;
  logic [5:0]  cw;
  logic [15:0] tab_a, tab_b;
  logic [3:0]  pidx;

  assign wr_go = (st_reg == dfr_pkg::BUS_DATA) & w_reg;
  assign cw    = 6'(a_reg[7:2] - dfr_pkg::CURVE_BASE[7:2]);

  always_comb begin
    st_next   = st_reg;
    a_next    = a_reg;
    w_next    = w_reg;
    rdy_next  = rdy_reg;
    rd_next   = rd_reg;
    ctrl_next = ctrl_reg;
    bind_next = bind_reg;
    maxf_next = maxf_reg;
    csel_next = csel_reg;
    dig_next  = dig_reg;
    host_next = host_reg;
    fmap_next = fmap_reg;
    slen_next = slen_reg;
    ppm_next  = ppm_reg;
    pthr_next = pthr_reg;
    crv_next  = crv_reg;
    unique case (st_reg)
      dfr_pkg::BUS_IDLE: begin
        if (hsel_in && htrans_in[1] && hready_in) begin
          a_next   = haddr_in[7:0];
          w_next   = hwrite_in & (hsize_in == 3'h2);
          rdy_next = 1'b0;
          st_next  = dfr_pkg::BUS_DATA;
        end
      end
      dfr_pkg::BUS_DATA: begin
        rdy_next = 1'b1;
        st_next  = dfr_pkg::BUS_IDLE;
        if (!w_reg) begin
          rd_next = rd_mux;
        end
      end
    endcase
    if (wr_go) begin
      case (a_reg)
        dfr_pkg::REG_CTRL:   ctrl_next = hwdata_in;
        dfr_pkg::REG_BIND:   bind_next = hwdata_in[11:0];
        dfr_pkg::REG_MAXF:   maxf_next = hwdata_in[15:0];
        dfr_pkg::REG_CSEL:   csel_next = hwdata_in[8:0];
        dfr_pkg::REG_DIG:    dig_next  = hwdata_in[15:0];
        dfr_pkg::REG_HOST:   host_next = hwdata_in[15:0];
        dfr_pkg::REG_FMAPL:  fmap_next[31:0]  = hwdata_in;
        dfr_pkg::REG_FMAPH:  fmap_next[63:32] = hwdata_in;
        dfr_pkg::REG_SETLEN: slen_next = hwdata_in;
        dfr_pkg::REG_PPM:    ppm_next  = hwdata_in[15:0];
        dfr_pkg::REG_PTHR:   pthr_next = hwdata_in[15:0];
        default: begin
          if (a_reg >= dfr_pkg::CURVE_BASE && cw < 6'(dfr_pkg::CURVE_WORDS)) begin
            crv_next[cw[4:0]] = hwdata_in[15:0]; // R7 R9
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_reg   <= dfr_pkg::BUS_IDLE;
      a_reg    <= 8'h00;
      w_reg    <= 1'b0;
      rdy_reg  <= 1'b1;
      rd_reg   <= 32'h0000_0000;
      ctrl_reg <= dfr_pkg::CTRL_RST;
      bind_reg <= 12'h000;
      maxf_reg <= dfr_pkg::MAXF_RST;
      csel_reg <= 9'h000;
      dig_reg  <= 16'h0000;
      host_reg <= 16'h0000;
      fmap_reg <= 64'h0000_0000_0000_0000;
      slen_reg <= dfr_pkg::SETLEN_RST;
      ppm_reg  <= dfr_pkg::PPM_RST;
      pthr_reg <= 16'h0000;
      crv_reg  <= '{default: 16'h0000};
    end else begin
      st_reg   <= st_next;
      a_reg    <= a_next;
      w_reg    <= w_next;
      rdy_reg  <= rdy_next;
      rd_reg   <= rd_next;
      ctrl_reg <= ctrl_next;
      bind_reg <= bind_next;
      maxf_reg <= maxf_next;
      csel_reg <= csel_next;
      dig_reg  <= dig_next;
      host_reg <= host_next;
      fmap_reg <= fmap_next;
      slen_reg <= slen_next;
      ppm_reg  <= ppm_next;
      pthr_reg <= pthr_next;
      crv_reg  <= crv_next;
    end
  end

  // preset table, read B follows the address phase so data meet the data phase
  dfr_ram #(.W(16), .D(16)) u_tab (
    .clock_in    (clock_in),
    .we_in       (wr_go && a_reg[7:6] == dfr_pkg::PRESET_TOP),
    .waddr_in    (a_reg[5:2]),
    .wdata_in    (hwdata_in[15:0]),
    .raddr_a_in  (pidx),
    .rdata_a_out (tab_a),
    .raddr_b_in  (haddr_in[5:2]),
    .rdata_b_out (tab_b)
  );

  for (genvar k = 0; k < 4; k++) begin : g_pidx
    assign pidx[k] = dfr_has(lvl, fmap_reg, 8'(dfr_pkg::FN_MS0 + 8'(k))); // R12 R14 R15
  end

  // pulse rate over a gate window, length counter
  logic [23:0] gcnt_reg, gcnt_next;
  logic [15:0] ecnt_reg, ecnt_next;
  logic [15:0] rate_reg, rate_next;
  logic [31:0] lcnt_reg, lcnt_next;
  logic [31:0] act_reg, act_next;
  logic        gate_end, len_clr, len_on;

  assign gate_end = (gcnt_reg == GC_LAST);
  assign len_clr  = dfr_has(lvl, fmap_reg, dfr_pkg::FN_LEN_CLR);
  assign len_on   = (fmap_reg[dfr_pkg::HS_DI*8 +: 8] == dfr_pkg::FN_LEN_CNT); // R22

  always_comb begin
    gcnt_next = gate_end ? 24'h00_0000 : 24'(gcnt_reg + 24'h00_0001);
    ecnt_next = ecnt_reg;
    rate_next = rate_reg;
    if (gate_end) begin
      rate_next = (ecnt_reg > PMAX) ? PMAX : ecnt_reg; // R8
      ecnt_next = {15'h0000, hs_edge};
    end else if (hs_edge && ecnt_reg != 16'hffff) begin
      ecnt_next = 16'(ecnt_reg + 16'h0001);
    end
    lcnt_next = lcnt_reg;
    if (len_clr) begin
      lcnt_next = 32'h0000_0000; // R21
    end else if (len_on && hs_edge && lcnt_reg != 32'hffff_ffff) begin
      lcnt_next = 32'(lcnt_reg + 32'h0000_0001); // R19 R22 R24
    end
    act_next = lcnt_reg / ((ppm_reg == 16'h0000) ? 32'h0000_0001 : 32'(ppm_reg)); // R19 R24
  end

  // frequency path
  logic signed [15:0] ai_x [3];
  logic [9:0][15:0]   src;
  logic signed [16:0] mv, av, opv, sel, tgt_next, tgt_reg, mx;
  logic signed [33:0] prod;
  logic [2:0]         ci;
  logic [3:0]         bd, msel, asel;
  logic [1:0]         csrc;
  logic               unit_sel, chsw;

  assign ai_x[0] = ai1_in;
  assign ai_x[1] = ai2_in;
  assign ai_x[2] = ai3_in;
  assign msel    = ctrl_reg[dfr_pkg::CF_MAIN +: 4];
  assign asel    = ctrl_reg[dfr_pkg::CF_AUX +: 4];
  assign csrc    = ctrl_reg[dfr_pkg::CF_CSRC +: 2];
  assign chsw    = dfr_has(lvl, fmap_reg, dfr_pkg::FN_CH_SW);
  assign mx      = 17'($signed({1'b0, maxf_reg}));
  assign unit_sel = ctrl_reg[dfr_pkg::CF_PAUT] ?
                    ((pid_err_in < 0 ? -pid_err_in : pid_err_in) > $signed(pthr_reg)) :
                    dfr_has(lvl, fmap_reg, dfr_pkg::FN_PID_SW); // R11

  always_comb begin
    src[dfr_pkg::SRC_DIG_V] = dig_reg; // R23
    src[dfr_pkg::SRC_DIG_R] = dig_reg;
    for (int k = 0; k < 3; k++) begin
      ci = csel_reg[k*3 +: 3];
      ci = (ci >= 3'(dfr_pkg::NUM_CURVES)) ? 3'h0 : ci; // R7
      src[int'(dfr_pkg::SRC_AI1) + k] = dfr_curve(ai_x[k], crv_reg[ci*4],
        crv_reg[ci*4 + 1], crv_reg[ci*4 + 2], crv_reg[ci*4 + 3]); // R6
    end
    src[dfr_pkg::SRC_PULSE] = dfr_curve($signed(rate_reg), crv_reg[dfr_pkg::PULSE_CURVE*4],
      crv_reg[dfr_pkg::PULSE_CURVE*4 + 1], crv_reg[dfr_pkg::PULSE_CURVE*4 + 2],
      crv_reg[dfr_pkg::PULSE_CURVE*4 + 3]); // R9
    src[dfr_pkg::SRC_PRESET] = tab_a; // R13 R14
    src[dfr_pkg::SRC_SEQ]    = seq_set_in;
    src[dfr_pkg::SRC_PID]    = unit_sel ? pid1_in : pid0_in; // R10 R11
    src[dfr_pkg::SRC_HOST]   = host_reg;
    mv = dfr_pick(src, msel);
    av = dfr_pick(src, asel); // R1
    unique case (dfr_pkg::dfr_op_t'(ctrl_reg[dfr_pkg::CF_OP +: 2])) // R3
      dfr_pkg::OP_SUM:  opv = mv + av;
      dfr_pkg::OP_DIFF: opv = mv - av;
      dfr_pkg::OP_MAX:  opv = (mv > av) ? mv : av;
      dfr_pkg::OP_MIN:  opv = (mv < av) ? mv : av;
    endcase
    unique case (dfr_pkg::dfr_cmb_t'(ctrl_reg[dfr_pkg::CF_CMB +: 2]))
      dfr_pkg::CMB_MAIN: sel = mv; // R2
      dfr_pkg::CMB_AUX:  sel = av;
      dfr_pkg::CMB_OP:   sel = opv;
      dfr_pkg::CMB_SW: begin
        unique case (ctrl_reg[dfr_pkg::CF_SW +: 2]) // R4
          dfr_pkg::SW_MA: sel = chsw ? av : mv;
          dfr_pkg::SW_MC: sel = chsw ? opv : mv;
          dfr_pkg::SW_AC: sel = chsw ? opv : av;
          default:        sel = mv;
        endcase
      end
    endcase
    bd = (csrc == 2'b11) ? 4'h0 : bind_reg[{csrc, 2'b00} +: 4];
    if (bd != 4'h0 && bd <= 4'(dfr_pkg::NUM_SRC)) begin
      sel = dfr_pick(src, 4'(bd - 4'h1)); // R5
    end
    prod = 34'(sel) * 34'(mx); // R6 R14
    prod = prod >>> dfr_pkg::FULL_SHIFT;
    if (prod > 34'(mx)) begin
      tgt_next = mx; // R25
    end else if (prod < -34'(mx)) begin
      tgt_next = -mx;
    end else begin
      tgt_next = 17'(prod);
    end
  end

  // output stage
  logic        neg, rq_rev, blk;
  logic [15:0] fq_reg, fq_next;
  logic        rev_reg, rev_next, en_reg, en_next, lr_reg, lr_next, pa_reg, pu_reg;

  assign neg    = tgt_reg[16];
  assign rq_rev = neg | rev_cmd_in; // R17
  assign blk    = ctrl_reg[dfr_pkg::CF_RINH] & rq_rev; // R18

  always_comb begin
    fq_next  = blk ? 16'h0000 : 16'(neg ? -tgt_reg : tgt_reg); // R18
    rev_next = ~blk & (rq_rev ^ ctrl_reg[dfr_pkg::CF_DINV]); // R16 R17
    en_next  = run_cmd_in & ~blk; // R18
    lr_next  = (act_reg > slen_reg); // R20
  end

  always_ff @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
      gcnt_reg <= 24'h00_0000;
      ecnt_reg <= 16'h0000;
      rate_reg <= 16'h0000;
      lcnt_reg <= 32'h0000_0000;
      act_reg  <= 32'h0000_0000;
      tgt_reg  <= 17'sd0;
      fq_reg   <= 16'h0000;
      rev_reg  <= 1'b0;
      en_reg   <= 1'b0;
      lr_reg   <= 1'b0;
      pa_reg   <= 1'b0;
      pu_reg   <= 1'b0;
    end else begin
      gcnt_reg <= gcnt_next;
      ecnt_reg <= ecnt_next;
      rate_reg <= rate_next;
      lcnt_reg <= lcnt_next;
      act_reg  <= act_next;
      tgt_reg  <= tgt_next;
      fq_reg   <= fq_next;
      rev_reg  <= rev_next;
      en_reg   <= en_next;
      lr_reg   <= lr_next;
      pa_reg   <= (msel == dfr_pkg::SRC_PID); // R10
      pu_reg   <= unit_sel;
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    case (a_reg)
      dfr_pkg::REG_CTRL:   rd_mux = ctrl_reg;
      dfr_pkg::REG_BIND:   rd_mux = {20'h0_0000, bind_reg};
      dfr_pkg::REG_MAXF:   rd_mux = {16'h0000, maxf_reg};
      dfr_pkg::REG_CSEL:   rd_mux = {23'h00_0000, csel_reg};
      dfr_pkg::REG_DIG:    rd_mux = {16'h0000, dig_reg};
      dfr_pkg::REG_HOST:   rd_mux = {16'h0000, host_reg};
      dfr_pkg::REG_FMAPL:  rd_mux = fmap_reg[31:0];
      dfr_pkg::REG_FMAPH:  rd_mux = fmap_reg[63:32];
      dfr_pkg::REG_SETLEN: rd_mux = slen_reg;
      dfr_pkg::REG_PPM:    rd_mux = {16'h0000, ppm_reg};
      dfr_pkg::REG_PTHR:   rd_mux = {16'h0000, pthr_reg};
      dfr_pkg::REG_STAT:   rd_mux = {24'h00_0000, pidx, pu_reg, en_reg, rev_reg, lr_reg};
      dfr_pkg::REG_ACTLEN: rd_mux = act_reg;
      dfr_pkg::REG_TGT:    rd_mux = 32'(tgt_reg);
      dfr_pkg::REG_LCNT:   rd_mux = lcnt_reg;
      dfr_pkg::REG_PRATE:  rd_mux = {16'h0000, rate_reg};
      default: begin
        if (a_reg[7:6] == dfr_pkg::PRESET_TOP) begin
          rd_mux = {16'h0000, tab_b};
        end else if (a_reg >= dfr_pkg::CURVE_BASE && cw < 6'(dfr_pkg::CURVE_WORDS)) begin
          rd_mux = {16'h0000, crv_reg[cw[4:0]]};
        end
      end
    endcase
  end

  assign hreadyout_out   = rdy_reg;
  assign hrdata_out      = rd_reg;
  assign hresp_out       = 1'b0 & rdy_reg;
  assign freq_out        = fq_reg;
  assign reverse_out     = rev_reg;
  assign drive_en_out    = en_reg;
  assign len_reached_out = lr_reg;
  assign pid_active_out  = pa_reg;
  assign pid_unit_out    = pu_reg;

  default clocking @(posedge clock_in); endclocking
  default disable iff (!rstn_in);

  property p_clamp;
    tgt_reg <= 17'($signed({1'b0, $past(maxf_reg)})) &&
    tgt_reg >= -17'($signed({1'b0, $past(maxf_reg)}));
  endproperty
  a_clamp: assert property (p_clamp) else $error("target beyond max frequency"); // R25
  property p_inhibit;
    ctrl_reg[dfr_pkg::CF_RINH] && (tgt_reg[16] || rev_cmd_in)
    |=> freq_out == 16'h0000 && !drive_en_out && !reverse_out;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("reverse not inhibited"); // R18
  property p_host_rev;
    msel == dfr_pkg::SRC_HOST && !ctrl_reg[dfr_pkg::CF_RINH] &&
    !ctrl_reg[dfr_pkg::CF_DINV] && tgt_reg[16] |=> reverse_out;
  endproperty
  a_host_rev: assert property (p_host_rev) else $error("negative host set not reverse"); // R17
  property p_invert;
    !ctrl_reg[dfr_pkg::CF_RINH] && ctrl_reg[dfr_pkg::CF_DINV] && !tgt_reg[16] &&
    !rev_cmd_in |=> reverse_out;
  endproperty
  a_invert: assert property (p_invert) else $error("direction not inverted"); // R16
  property p_pid;
    msel == dfr_pkg::SRC_PID ##1 msel != dfr_pkg::SRC_PID |=> !pid_active_out;
  endproperty
  a_pid: assert property (p_pid) else $error("pid active outside code 8"); // R10
  property p_len_clr;
    len_clr |=> lcnt_reg == 32'h0000_0000 ##1 (act_reg == 32'h0000_0000);
  endproperty
  a_len_clr: assert property (p_len_clr) else $error("length not cleared"); // R21
  property p_len_mono;
    !len_clr |=> lcnt_reg >= $past(lcnt_reg);
  endproperty
  a_len_mono: assert property (p_len_mono) else $error("length count went down"); // R22
  property p_reach;
    act_reg > slen_reg |=> len_reached_out;
  endproperty
  a_reach: assert property (p_reach) else $error("length reached not shown"); // R20
  property p_bus;
    hsel_in && htrans_in[1] && hready_in && hreadyout_out |=> !hreadyout_out ##1 hreadyout_out;
  endproperty
  a_bus: assert property (p_bus) else $error("bus wait state not one cycle");

  c_reach:  cover property ($rose(len_reached_out));
  c_rev:    cover property (reverse_out && drive_en_out && freq_out != 16'h0000);
  c_preset: cover property (msel == dfr_pkg::SRC_PRESET && pidx == 4'h2 && freq_out != 16'h0000);
  c_read:   cover property (st_reg == dfr_pkg::BUS_DATA && !w_reg);
endmodule : dfr_top

// >>> testbench/dfr_far.sv
module dfr_far (
  // clock
  input  wire logic          clock_in,
  // levels and reverse request from the bench
  input  wire logic [7:0]    lvl_in,
  input  wire logic          rev_in,
  // terminals and analog lines
  output logic [7:0]         di_out,
  output logic signed [15:0] ai_out,
  output logic               run_out,
  output logic               rev_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic               pulse_reg = 1'b0;
  logic signed [15:0] wob_reg   = 16'sh0000;
  // analog line never sits still, so no stale value passes for a sample
  always @(posedge clock_in) wob_reg <= wob_reg + 16'sh0001;
  assign ai_out  = wob_reg;
  assign di_out  = lvl_in | {3'b000, pulse_reg, 4'h0};
  assign run_out = 1'b1;
  assign rev_out = rev_in;
  // slow pulses on the high-speed terminal, up count only
  task automatic pulse(input int n);
    repeat (n) begin
      @(posedge clock_in);
      pulse_reg <= 1'b1;
      repeat (3) @(posedge clock_in);
      pulse_reg <= 1'b0;
      repeat (3) @(posedge clock_in);
    end
  endtask : pulse
endmodule : dfr_far

// >>> testbench/test_dfr_top.sv
module test_dfr_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_in = 1'b0, rstn_in = 1'b0, hsel_in = 1'b0, hwrite_in = 1'b0;
  logic [31:0] haddr_in = 32'h0000_0000, hwdata_in = 32'h0000_0000, hrdata_out, q;
  logic [1:0] htrans_in = 2'b00;
  logic [2:0] hsize_in = 3'b010;
  logic hready_in, hreadyout_out, hresp_out, run_cmd_in, rev_cmd_in, rev_req = 1'b0;
  logic [7:0] di_in, lvl = 8'h00;
  logic signed [15:0] ai1_in, ai3_in, ai2_in = 16'sh0000, seq_set_in = 16'sh0000;
  logic signed [15:0] pid0_in = 16'sh0000, pid1_in = 16'sh0000, pid_err_in = 16'sh0000;
  logic [15:0] freq_out;
  logic reverse_out, drive_en_out, len_reached_out, pid_active_out, pid_unit_out;
  logic [31:0] rnd = 32'h0000_bac4;
  int bad_count = 0, check_count = 0, n;
  assign hready_in = hreadyout_out;
  assign ai3_in = ~ai1_in;
  always #12.5 clock_in = ~clock_in;
  dfr_top #(.GATE_CYC(4000)) dfr_top_inst (.*);
  dfr_far dfr_far_inst (.clock_in(clock_in), .lvl_in(lvl), .rev_in(rev_req), .di_out(di_in),
    .ai_out(ai1_in), .run_out(run_cmd_in), .rev_out(rev_cmd_in));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel_in <= 1'b1;
    htrans_in <= 2'b10;
    haddr_in <= {24'h00_0000, a};
    hwrite_in <= w;
    // ready only changes on rising edges, so its mid-cycle level is what the edge samples
    do @(negedge clock_in); while (hreadyout_out !== 1'b1);
    @(posedge clock_in);
    htrans_in <= 2'b00;
    hwdata_in <= d;
    do @(negedge clock_in); while (hreadyout_out !== 1'b1);
    q = hrdata_out;
    @(posedge clock_in);
  endtask : bus
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(q, e);
    chk({31'h0, hresp_out}, 32'h0000_0000);
  endtask : rdc
  task automatic host(input logic [31:0] c, input logic [31:0] h);
    bus(1'b1, dfr_pkg::REG_CTRL, c);
    bus(1'b1, dfr_pkg::REG_HOST, h);
    repeat (8) @(posedge clock_in);
  endtask : host
  task automatic test_done;
    if (bad_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  initial begin
    #1000000;
    bad_count++;
    test_done();
  end
  initial begin
    repeat (3) @(posedge clock_in);
    rstn_in <= 1'b1;
    @(posedge clock_in);
    rdc(dfr_pkg::REG_MAXF, 32'h0000_1388);
    rdc(dfr_pkg::REG_CTRL, 32'h0000_0000);
    rdc(8'ha0, 32'h0000_0000);
    host(32'h0000_0009, 32'h0000_4000);
    chk({drive_en_out, reverse_out, freq_out}, 32'h0002_1388);
    host(32'h0000_0009, 32'hffff_c000);
    chk({drive_en_out, reverse_out, freq_out}, 32'h0003_1388);
    host(32'h0000_8009, 32'hffff_c000);
    chk({drive_en_out, freq_out}, 32'h0000_0000);
    host(32'h0000_4009, 32'h0000_4000);
    chk({31'h0, reverse_out}, 32'h0000_0001);
    rev_req <= 1'b1;
    host(32'h0000_8009, 32'h0000_4000);
    chk({drive_en_out, reverse_out, freq_out}, 32'h0000_0000);
    rev_req <= 1'b0;
    pid_err_in <= 16'sh0100;
    host(32'h0004_0008, 32'h0000_0000);
    chk({30'h0, pid_unit_out, pid_active_out}, 32'h0000_0003);
    bus(1'b1, dfr_pkg::REG_FMAPL, 32'h0000_0d0c);
    bus(1'b1, 8'hc8, 32'h0000_2000);
    lvl <= 8'h02;
    host(32'h0000_0006, 32'h0000_0000);
    chk({16'h0, freq_out}, 32'h0000_09c4);
    rnd = lfsr(lfsr(rnd));
    n = 2 + int'(rnd[2:0]);
    bus(1'b1, dfr_pkg::REG_FMAPH, 32'h0000_1c1b);
    bus(1'b1, dfr_pkg::REG_PPM, 32'h0000_0002);
    bus(1'b1, dfr_pkg::REG_SETLEN, 32'h0000_0000);
    dfr_far_inst.pulse(n);
    repeat (6) @(posedge clock_in);
    rdc(dfr_pkg::REG_LCNT, 32'(n));
    rdc(dfr_pkg::REG_ACTLEN, 32'(n / 2));
    chk({31'h0, len_reached_out}, 32'h0000_0001);
    lvl <= 8'h20;
    repeat (6) @(posedge clock_in);
    rdc(dfr_pkg::REG_LCNT, 32'h0000_0000);
    test_done();
  end
endmodule : test_dfr_top
